// File: design/aet_pkg.sv
// Constants, register map and state codes of the acquisition trigger and exposure control
package aet_pkg;

   localparam int CLK_NS     = 5;
   localparam int US_NS      = 1000;
   localparam int CYC_PER_US = US_NS / CLK_NS;
   localparam int PRE_W      = 8;
   localparam int TW         = 24;
   localparam int AW         = 8;
   localparam int CTRL_W     = 6;

   localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(CYC_PER_US - 1);

   // Byte offsets on the register bus
   localparam logic [AW-1:0] OFS_CTRL  = 8'h00;
   localparam logic [AW-1:0] OFS_CMD   = 8'h04;
   localparam logic [AW-1:0] OFS_EXP   = 8'h08;
   localparam logic [AW-1:0] OFS_LIMIT = 8'h0c;
   localparam logic [AW-1:0] OFS_MINP  = 8'h10;
   localparam logic [AW-1:0] OFS_STAT  = 8'h14;

   // Control fields
   localparam int CTRL_SINGLE = 0;
   localparam int CTRL_SRC_LO = 1;
   localparam int CTRL_FALL   = 3;
   localparam int CTRL_WIDTH  = 4;
   localparam int CTRL_FRLE   = 5;

   localparam logic [1:0] SRC_SW    = 2'h0;
   localparam logic [1:0] SRC_LINE1 = 2'h1;
   localparam logic [1:0] SRC_LINE2 = 2'h2;

   localparam logic [CTRL_W-1:0] CTRL_RST = 6'h02;

   // Command bits, write only, self clearing
   localparam int CMD_START = 0;
   localparam int CMD_STOP  = 1;
   localparam int CMD_SWTRG = 2;

   // Status bits
   localparam int ST_ARMED  = 0;
   localparam int ST_EXPOSE = 1;
   localparam int ST_READY  = 2;
   localparam int ST_EXTEND = 3;
   localparam int ST_RDBUSY = 4;

   localparam logic [TW-1:0] EXP_RST   = 24'h0003e8;
   localparam logic [TW-1:0] LIMIT_RST = 24'h004e20;
   localparam logic [TW-1:0] MINP_RST  = 24'h0007d0;

   typedef enum logic [3:0] {
      AET_IDLE   = 4'h1,
      AET_TIMED  = 4'h2,
      AET_WIDTH  = 4'h4,
      AET_EXTEND = 4'h8
   } aet_state_e;

endpackage

// File: design/aet_line_if.sv
// Conditioned trigger line: level and edge pulses
`timescale 1ns/1ps
interface aet_line_if;
   logic level;
   logic rise;
   logic fall;
   modport src (output level, output rise, output fall);
   modport snk (input level, input rise, input fall);
endinterface

// File: design/aet_line_sync.sv
// Three-stage synchroniser and edge detector for one trigger input line
`timescale 1ns/1ps
module aet_line_sync
   import aet_pkg::*;
(
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic pin,
   aet_line_if.src   line
);

   logic [2:0] s_reg;
   logic [2:0] s_next;
   logic       lvl_reg;
   logic       lvl_next;
   logic       rise_reg;
   logic       rise_next;
   logic       fall_reg;
   logic       fall_next;

   // Level changes only when second and third stage agree
   always_comb
   begin
      s_next    = {s_reg[1:0], pin};
      lvl_next  = (s_reg[1] == s_reg[2]) ? s_reg[2] : lvl_reg;
      rise_next = lvl_next & ~lvl_reg;
      fall_next = ~lvl_next & lvl_reg;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_reg    <= 3'h0;
         lvl_reg  <= 1'b0;
         rise_reg <= 1'b0;
         fall_reg <= 1'b0;
      end
      else
      begin
         s_reg    <= s_next;
         lvl_reg  <= lvl_next;
         rise_reg <= rise_next;
         fall_reg <= fall_next;
      end
   end

   assign line.level = lvl_reg;
   assign line.rise  = rise_reg;
   assign line.fall  = fall_reg;

endmodule

// File: design/aet_us_timer.sv
// Microsecond down-counter: load a count, busy while running, done pulse at the end
`timescale 1ns/1ps
module aet_us_timer
   import aet_pkg::*;
(
   input  wire logic          clk,
   input  wire logic          rst_n,
   input  wire logic          load,
   input  wire logic [TW-1:0] value,
   output logic               busy,
   output logic               done
);

   logic [PRE_W-1:0] pre_reg;
   logic [PRE_W-1:0] pre_next;
   logic [TW-1:0]    cnt_reg;
   logic [TW-1:0]    cnt_next;
   logic             done_reg;
   logic             done_next;
   logic             tick;

   assign tick = (pre_reg == PRE_LAST);

   always_comb
   begin
      pre_next  = '0;
      cnt_next  = cnt_reg;
      done_next = 1'b0;
      if (load)
      begin
         // A zero count would never finish, so it runs as one microsecond
         cnt_next = (value == '0) ? TW'(1) : value;
      end
      else if (cnt_reg != '0)
      begin
         pre_next = tick ? '0 : pre_reg + PRE_W'(1);
         if (tick)
         begin
            cnt_next  = cnt_reg - TW'(1);
            done_next = (cnt_reg == TW'(1));
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pre_reg  <= '0;
         cnt_reg  <= '0;
         done_reg <= 1'b0;
      end
      else
      begin
         pre_reg  <= pre_next;
         cnt_reg  <= cnt_next;
         done_reg <= done_next;
      end
   end

   assign busy = (cnt_reg != '0);
   assign done = done_reg;

endmodule

// File: design/aet_top.sv
// Acquisition trigger and exposure control with APB register access
//
// Overview of operation
// (R1) Continuous mode: start command arms for unlimited software triggers, one image each.
// (R2) Accepted software trigger starts exposure at once for the programmed duration.
// (R3) End of programmed exposure starts readout, then transmission, of the frame.
// (R4) Stop command disarms; later triggers ignored until armed again.
// (R5) Commanding party keeps trigger rate below the maximum allowed rate.
// (R6) Enabled frame-rate limit below maximum rate caps triggering at that limit.
// (R7) Enabled limit above maximum rate caps triggering at the maximum rate.
// (R8) External trigger on selectable line, rising or falling edge as configured.
// (R9) External control acquires one image per trigger period, periodic or not.
// (R10) After reset the external trigger source is input line 1.
// (R11) External triggering offers two exposure modes: timed and trigger width.
// (R12) Timed mode: exposure starts on active edge, lasts programmed time regardless.
// (R13) Width mode: exposure starts on active edge, ends on opposite edge.
// (R14) Width mode still uses programmed exposure time for trigger-ready timing.
// (R15) Width end during previous readout extends exposure until readout finishes.
// (R16) Width end after readout finished: exposure equals trigger active duration.
// (R17) Single-frame mode: after one accepted trigger, ignore others until rearmed.
// (R18) Trigger source applies edges only while trigger-ready output is high.
// (R19) Triggers arriving while not armed are discarded without exposure.
//
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
module aet_top
   import aet_pkg::*;
(
   input  wire logic          pclk,
   input  wire logic          presetn,
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [AW-1:0] paddr,
   input  wire logic [31:0]   pwdata,
   output logic      [31:0]   prdata,
   output logic               pready,
   output logic               pslverr,
   input  wire logic [1:0]    external_trigger_input,
   input  wire logic          readout_busy,
   output logic               exposure_active,
   output logic               readout_start,
   output logic               trigger_ready_output
);

   aet_line_if line_if [2] ();
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++)
      begin : g_line
         aet_line_sync u_sync
         (
            .clk   (pclk),
            .rst_n (presetn),
            .pin   (external_trigger_input[gi]),
            .line  (line_if[gi])
         );
      end
   endgenerate
   logic [1:0] l_rise;
   logic [1:0] l_fall;
   assign l_rise = {line_if[1].rise, line_if[0].rise};
   assign l_fall = {line_if[1].fall, line_if[0].fall};

   // Register bus
   logic [CTRL_W-1:0] ctrl_reg;
   logic [CTRL_W-1:0] ctrl_next;
   logic [TW-1:0]     exp_reg;
   logic [TW-1:0]     exp_next;
   logic [TW-1:0]     lim_reg;
   logic [TW-1:0]     lim_next;
   logic [TW-1:0]     minp_reg;
   logic [TW-1:0]     minp_next;
   logic              ack_reg;
   logic              ack_next;
   logic [31:0]       rd_reg;
   logic [31:0]       rd_next;
   logic              hit;
   logic              wr;
   logic [31:0]       stat;

   // Acquisition control
   aet_state_e        state_reg;
   aet_state_e        state_next;
   logic              armed_reg;
   logic              armed_next;
   logic              ro_reg;
   logic              ro_next;
   logic              rdy_reg;
   logic              rdy_next;
   logic [1:0]        src;
   logic              sel2;
   logic              fall_act;
   logic              width_mode;
   logic              cmd_start;
   logic              cmd_stop;
   logic              sw_trig;
   logic              trig_evt;
   logic              end_edge;
   logic              accept;
   logic [TW-1:0]     per_val;
   logic              exp_busy;
   logic              exp_done;
   logic              per_busy;

   assign hit = (paddr == OFS_CTRL) || (paddr == OFS_CMD) || (paddr == OFS_EXP) ||
                (paddr == OFS_LIMIT) || (paddr == OFS_MINP) || (paddr == OFS_STAT);

   assign wr      = psel & penable & ack_reg & pwrite & hit;
   assign pready  = ack_reg;
   assign pslverr = ack_reg & ~hit;
   assign prdata  = rd_reg;

   always_comb
   begin
      stat            = '0;
      stat[ST_ARMED]  = armed_reg;
      stat[ST_EXPOSE] = (state_reg != AET_IDLE);
      stat[ST_READY]  = rdy_reg;
      stat[ST_EXTEND] = (state_reg == AET_EXTEND);
      stat[ST_RDBUSY] = readout_busy;
   end

   // One wait state: read data is captured in the first access cycle
   always_comb
   begin
      ack_next  = psel & penable & ~ack_reg;
      rd_next   = rd_reg;
      ctrl_next = ctrl_reg;
      exp_next  = exp_reg;
      lim_next  = lim_reg;
      minp_next = minp_reg;
      if (psel && penable && !ack_reg && !pwrite)
      begin
         case (paddr)
            OFS_CTRL:  rd_next = {{(32-CTRL_W){1'b0}}, ctrl_reg};
            OFS_EXP:   rd_next = {8'h00, exp_reg};
            OFS_LIMIT: rd_next = {8'h00, lim_reg};
            OFS_MINP:  rd_next = {8'h00, minp_reg};
            OFS_STAT:  rd_next = stat;
            default:   rd_next = '0;
         endcase
      end
      if (wr)
      begin
         case (paddr)
            OFS_CTRL:  ctrl_next = pwdata[CTRL_W-1:0];
            OFS_EXP:   exp_next  = pwdata[TW-1:0];
            OFS_LIMIT: lim_next  = pwdata[TW-1:0];
            OFS_MINP:  minp_next = pwdata[TW-1:0];
            default:   ctrl_next = ctrl_reg;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ack_reg  <= 1'b0;
         rd_reg   <= '0;
         ctrl_reg <= CTRL_RST; // R10
         exp_reg  <= EXP_RST;
         lim_reg  <= LIMIT_RST;
         minp_reg <= MINP_RST;
      end
      else
      begin
         ack_reg  <= ack_next;
         rd_reg   <= rd_next;
         ctrl_reg <= ctrl_next;
         exp_reg  <= exp_next;
         lim_reg  <= lim_next;
         minp_reg <= minp_next;
      end
   end

   // Trigger selection
   assign src        = ctrl_reg[CTRL_SRC_LO+:2];
   assign sel2       = (src == SRC_LINE2);
   assign fall_act   = ctrl_reg[CTRL_FALL];
   assign width_mode = ctrl_reg[CTRL_WIDTH] && (src != SRC_SW); // R11
   assign cmd_start  = wr && (paddr == OFS_CMD) && pwdata[CMD_START];
   assign cmd_stop   = wr && (paddr == OFS_CMD) && pwdata[CMD_STOP];
   assign sw_trig    = wr && (paddr == OFS_CMD) && pwdata[CMD_SWTRG] && (src == SRC_SW);

   always_comb
   begin
      trig_evt = sw_trig; // R2
      end_edge = 1'b0;
      if (src == SRC_LINE1 || src == SRC_LINE2)
      begin
         trig_evt = fall_act ? l_fall[sel2] : l_rise[sel2]; // R8 R9
         end_edge = fall_act ? l_rise[sel2] : l_fall[sel2]; // R13
      end
   end
   // With the limit enabled, the slower of the limit period and the shortest allowed period wins; otherwise the shortest allowed period
   assign per_val = (ctrl_reg[CTRL_FRLE] && lim_reg > minp_reg) ? lim_reg : minp_reg; // R6 R7
   // Exposure timer also runs in width mode to time the ready output
   assign accept = trig_evt && armed_reg && (state_reg == AET_IDLE) && !per_busy && !exp_busy; // R19 R4
   aet_us_timer u_exp
   (
      .clk   (pclk),
      .rst_n (presetn),
      .load  (accept),
      .value (exp_reg),
      .busy  (exp_busy),
      .done  (exp_done)
   );
   aet_us_timer u_per
   (
      .clk   (pclk),
      .rst_n (presetn),
      .load  (accept),
      .value (per_val),
      .busy  (per_busy),
      .done  ()
   );
   always_comb
   begin
      state_next = state_reg;
      armed_next = armed_reg;
      ro_next    = 1'b0;
      if (cmd_start)
      begin
         armed_next = 1'b1; // R1
      end
      if (accept && ctrl_reg[CTRL_SINGLE])
      begin
         armed_next = 1'b0; // R17
      end
      if (cmd_stop)
      begin
         armed_next = 1'b0; // R4
      end
      case (state_reg)
         AET_IDLE:
         begin
            if (accept)
            begin
               state_next = width_mode ? AET_WIDTH : AET_TIMED; // R2 R12
            end
         end
         AET_TIMED:
         begin
            if (exp_done)
            begin
               state_next = AET_IDLE;
               ro_next    = 1'b1; // R3
            end
         end
         AET_WIDTH:
         begin
            if (end_edge)
            begin
               if (readout_busy)
               begin
                  state_next = AET_EXTEND; // R15
               end
               else
               begin
                  state_next = AET_IDLE;
                  ro_next    = 1'b1; // R16
               end
            end
         end
         AET_EXTEND:
         begin
            if (!readout_busy)
            begin
               state_next = AET_IDLE;
               ro_next    = 1'b1; // R15
            end
         end
         default:
         begin
            state_next = AET_IDLE;
         end
      endcase
      rdy_next = armed_next && (state_next == AET_IDLE) && !per_busy && !exp_busy; // R14 R18
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_reg <= AET_IDLE;
         armed_reg <= 1'b0;
         ro_reg    <= 1'b0;
         rdy_reg   <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         armed_reg <= armed_next;
         ro_reg    <= ro_next;
         rdy_reg   <= rdy_next;
      end
   end
   assign exposure_active      = (state_reg != AET_IDLE);
   assign readout_start        = ro_reg;
   assign trigger_ready_output = rdy_reg;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence s_width_end;
      (state_reg == AET_WIDTH) && end_edge && !readout_busy;
   endsequence
   sequence s_extend_release;
      (state_reg == AET_EXTEND) && !readout_busy;
   endsequence
   a_start_arms_device: assert property (cmd_start && !cmd_stop |=> armed_reg) // R1
      else $error("start command did not arm");
   a_accept_starts_expose: assert property (accept |=> exposure_active) // R2
      else $error("accepted trigger did not start exposure");
   a_timed_end_readout: assert property ((state_reg == AET_TIMED) && exp_done |=> readout_start && !exposure_active) // R3
      else $error("timed exposure end did not start readout");
   a_stop_blocks_trigger: assert property (cmd_stop |=> !armed_reg ##0 !accept) // R4
      else $error("stop command did not disarm");
   a_rate_gap_held: assert property (accept |=> per_busy && !trigger_ready_output) // R6 R7
      else $error("trigger ready during frame period");
   a_timed_ignores_edge: assert property ((state_reg == AET_TIMED) && !exp_done |=> state_reg == AET_TIMED) // R12
      else $error("timed exposure ended early");
   a_width_ends_normal: assert property (s_width_end |=> readout_start && (state_reg == AET_IDLE)) // R13 R16
      else $error("width exposure did not end on opposite edge");
   a_extend_until_read: assert property ((state_reg == AET_EXTEND) && readout_busy |=> state_reg == AET_EXTEND) // R15
      else $error("extension ended during readout");
   a_extend_then_read: assert property (s_extend_release |=> readout_start ##1 !readout_start) // R15
      else $error("readout start missing after extension");
   a_single_disarms_dev: assert property (accept && ctrl_reg[CTRL_SINGLE] |=> !armed_reg) // R17
      else $error("single frame mode stayed armed");
   a_unarmed_discards: assert property (!armed_reg && (state_reg == AET_IDLE) |=> !exposure_active) // R19
      else $error("exposure while not armed");
   a_ready_tracks_exp: assert property (exp_busy |-> !trigger_ready_output) // R14
      else $error("trigger ready while exposure timer runs");

endmodule

// File: tb/aet_far_model.sv
// Far side model: trigger source on two lines and sensor readout
`timescale 1ns/1ps
module aet_far_model
   import aet_pkg::*;
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       readout_start,
   input  wire logic       trigger_ready_output,
   output logic      [1:0] external_trigger_input,
   output logic            readout_busy
);
   int rd_len = 0;
   int cnt;
   int late = 0;
   initial external_trigger_input = 2'h0;
   // Readout stays busy for rd_len cycles after each start pulse
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         readout_busy <= 1'b0;
         cnt <= 0;
      end
      else if (readout_start && rd_len > 0)
      begin
         readout_busy <= 1'b1;
         cnt <= rd_len;
      end
      else if (cnt > 1)
         cnt <= cnt - 1;
      else
      begin
         cnt <= 0;
         readout_busy <= 1'b0;
      end
   end
   task idle(input int ln, input logic v);
      @(posedge pclk);
      external_trigger_input[ln] <= v;
   endtask
   // Active edge once the device reports ready, or after 5000 cycles counted as late, then back after w cycles
   task pulse(input int ln, input int w);
      int n;
      n = 0;
      while (trigger_ready_output !== 1'b1 && n < 5000)
      begin
         @(negedge pclk);
         n++;
      end
      if (n >= 5000)
         late++;
      @(posedge pclk);
      external_trigger_input[ln] <= ~external_trigger_input[ln];
      repeat (w) @(posedge pclk);
      external_trigger_input[ln] <= ~external_trigger_input[ln];
   endtask
endmodule

// File: tb/aet_top_tb.sv
// Self-checking testbench of the acquisition trigger and exposure control
`timescale 1ns/1ps
module aet_top_tb
   import aet_pkg::*;
;
   logic          pclk = 1'b0;
   logic          presetn = 1'b0;
   logic          psel = 1'b0;
   logic          penable = 1'b0;
   logic          pwrite = 1'b0;
   logic [AW-1:0] paddr = '0;
   logic [31:0]   pwdata = '0;
   logic [31:0]   prdata;
   logic          pready;
   logic          pslverr;
   logic [1:0]    external_trigger_input;
   logic          readout_busy;
   logic          exposure_active;
   logic          readout_start;
   logic          trigger_ready_output;
   logic [31:0]   rdq;
   logic          rde;
   int            n_fail = 0;
   int            check_count = 0;
   int            len;

   always #2.5 pclk = ~pclk;

   aet_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .external_trigger_input(external_trigger_input), .readout_busy(readout_busy),
      .exposure_active(exposure_active), .readout_start(readout_start),
      .trigger_ready_output(trigger_ready_output));

   aet_far_model far (.pclk(pclk), .presetn(presetn), .readout_start(readout_start),
      .trigger_ready_output(trigger_ready_output), .external_trigger_input(external_trigger_input),
      .readout_busy(readout_busy));

   task report_and_stop;
      $display("checks %0d failures %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task chk(input logic ok, input string m);
      check_count++;
      if (ok !== 1'b1)
      begin
         n_fail++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask

   // One transfer: setup, access until pready is sampled high at a rising edge, release there
   task apb(input logic w, input logic [AW-1:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20)
      begin
         @(posedge pclk);
         n++;
      end
      if (n >= 20)
      begin
         chk(1'b0, "bus timeout");
         report_and_stop();
      end
      rdq = prdata;
      rde = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Waits for exposure, counts its cycles, checks the readout pulse at its end
   task expo(output int l);
      int n;
      n = 0;
      l = 0;
      while (exposure_active !== 1'b1 && n < 3000)
      begin
         @(negedge pclk);
         n++;
      end
      while (exposure_active === 1'b1 && l < 5000)
      begin
         @(negedge pclk);
         l++;
      end
      if (n >= 3000 || l >= 5000)
      begin
         chk(1'b0, "exposure timeout");
         report_and_stop();
      end
      chk(readout_start === 1'b1, "no readout pulse at exposure end");
   endtask

   // Starts half a cycle on, so the ready drop launched at the calling edge is seen
   task rdy_gap(output int g);
      g = 0;
      @(negedge pclk);
      while (trigger_ready_output !== 1'b1 && g < 5000)
      begin
         @(negedge pclk);
         g++;
      end
      if (g >= 5000)
      begin
         chk(1'b0, "ready timeout");
         report_and_stop();
      end
   endtask

   task quiet(input int c);
      logic seen;
      seen = 1'b0;
      repeat (c)
      begin
         @(negedge pclk);
         seen = seen | (exposure_active === 1'b1);
      end
      chk(seen === 1'b0, "exposure started while it should not");
   endtask

   task t_reset_regs;
      apb(0, OFS_CTRL, 0);
      chk(rdq === {26'h0, CTRL_RST}, "control reset value");
      apb(0, OFS_EXP, 0);
      chk(rdq === {8'h0, EXP_RST}, "exposure reset value");
      apb(0, OFS_LIMIT, 0);
      chk(rdq === {8'h0, LIMIT_RST}, "limit reset value");
      apb(0, OFS_MINP, 0);
      chk(rdq === {8'h0, MINP_RST}, "period reset value");
      apb(0, 8'h18, 0);
      chk(rde === 1'b1 && rdq === 32'h0, "unmapped read");
      apb(1, OFS_EXP, 32'h2);
      apb(1, OFS_MINP, 32'h2);
      apb(1, OFS_CTRL, 32'h0);
   endtask

   task t_unarmed_sw;
      apb(1, OFS_CMD, 32'h4);
      quiet(50);
   endtask

   task t_continuous_sw;
      apb(1, OFS_CMD, 32'h1);
      repeat (2)
      begin
         rdy_gap(len);
         apb(1, OFS_CMD, 32'h4);
         expo(len);
         chk(len >= 400 && len <= 402, "software exposure length");
      end
      rdy_gap(len);
      apb(1, OFS_CMD, 32'h2);
      apb(1, OFS_CMD, 32'h4);
      quiet(50);
   endtask

   task t_single;
      apb(1, OFS_CTRL, 32'h1);
      apb(1, OFS_CMD, 32'h1);
      apb(1, OFS_CMD, 32'h4);
      expo(len);
      chk(len >= 400 && len <= 402, "single exposure length");
      repeat (500) @(posedge pclk);
      apb(1, OFS_CMD, 32'h4);
      quiet(50);
      apb(0, OFS_STAT, 0);
      chk(rdq[ST_ARMED] === 1'b0, "still armed after single frame");
   endtask

   task t_rate_limit;
      apb(1, OFS_CTRL, 32'h20);
      apb(1, OFS_LIMIT, 32'h4);
      apb(1, OFS_CMD, 32'h1);
      rdy_gap(len);
      apb(1, OFS_CMD, 32'h4);
      rdy_gap(len);
      chk(len >= 795 && len <= 805, "limited period");
      apb(1, OFS_LIMIT, 32'h1);
      apb(1, OFS_CMD, 32'h4);
      rdy_gap(len);
      chk(len >= 395 && len <= 405, "period at maximum rate");
      apb(1, OFS_CMD, 32'h2);
   endtask

   task t_ext_timed;
      apb(1, OFS_CTRL, 32'h2);
      apb(1, OFS_CMD, 32'h1);
      repeat (2)
      begin
         fork
            far.pulse(0, 20);
            expo(len);
         join
         chk(len >= 400 && len <= 402, "timed line 1 exposure");
      end
      far.idle(1, 1'b1);
      apb(1, OFS_CTRL, 32'h0c);
      fork
         far.pulse(1, 20);
         expo(len);
      join
      chk(len >= 400 && len <= 402, "falling edge line 2 exposure");
      apb(1, OFS_CMD, 32'h2);
   endtask

   task t_width;
      far.rd_len = 2000;
      apb(1, OFS_CTRL, 32'h12);
      apb(1, OFS_CMD, 32'h1);
      fork
         far.pulse(0, 100);
         expo(len);
      join
      chk(len >= 98 && len <= 104, "width exposure length");
      chk(trigger_ready_output === 1'b0, "ready before exposure setting elapsed");
      fork
         far.pulse(0, 100);
         expo(len);
      join
      chk(len > 1000 && readout_busy === 1'b0, "exposure not extended to readout end");
      chk(far.late == 0, "trigger edge applied without ready");
   endtask

   initial
   begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      t_reset_regs();
      t_unarmed_sw();
      t_continuous_sw();
      t_single();
      t_rate_limit();
      t_ext_timed();
      t_width();
      report_and_stop();
   end

   initial
   begin
      repeat (100000) @(posedge pclk);
      chk(1'b0, "run timeout");
      report_and_stop();
   end
endmodule
